/* File: src/fsp_pkg.sv */
package fsp_pkg;
  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_BUSY = 0;
  localparam int unsigned BIT_LATCH = 1;
  localparam int unsigned BIT_BP_LO = 2;
  localparam int unsigned BIT_MODE_LOW = 7;
  localparam int unsigned BIT_MODE_HIGH = 8;
  localparam int unsigned BIT_QUAD = 9;
  localparam int unsigned BIT_PSUS = 10;
  localparam int unsigned BIT_LOCK_LO = 11;
  localparam int unsigned BIT_CMP = 14;
  localparam int unsigned BIT_ESUS = 15;
  // ----------------------------------------------------------------
  // Reset value of the non-volatile image and array geometry
  // ----------------------------------------------------------------
  localparam logic [15:0] NV_RESET = 16'h0000;
  localparam int unsigned ADDR_W = 23;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_QPP = 8'h32;
  localparam logic [7:0] CMD_SE = 8'h20;
  localparam logic [7:0] CMD_BE32 = 8'h52;
  localparam logic [7:0] CMD_BE64 = 8'hD8;
  localparam logic [7:0] CMD_CE1 = 8'h60;
  localparam logic [7:0] CMD_CE2 = 8'hC7;
  localparam logic [7:0] CMD_SUSP = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_RST_EN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  localparam logic [7:0] CMD_SEC_ER = 8'h44;
  localparam logic [7:0] CMD_SEC_PG = 8'h42;
  // ----------------------------------------------------------------
  // Internal operation times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned T_OP_US = 20;
  localparam int unsigned OP_CYCLES = T_OP_US * CLK_MHZ;
endpackage : fsp_pkg

/* File: src/fsp_prot_decode.sv */
`timescale 1ns/10ps
module fsp_prot_decode (
  input wire logic [4:0] i_bp,
  input wire logic i_cmp,
  input wire logic [fsp_pkg::ADDR_W-1:0] i_addr,
  output logic o_protected
);
  logic [2:0] lo;
  logic [fsp_pkg::ADDR_W-1:0] span_mask;
  logic in_range;
  logic normal;
  always_comb begin
    lo = i_bp[2:0];
    span_mask = '0;
    if (i_bp[4]) begin
      // Piece of 4KB to 32KB; codes 10x and 110 all give 32KB.
      unique case (lo)
        3'h1: span_mask = 23'h000FFF;
        3'h2: span_mask = 23'h001FFF;
        3'h3: span_mask = 23'h003FFF;
        default: span_mask = 23'h007FFF;
      endcase
    end else begin
      // Power-of-two fraction from 1/64 to 1/2 of the array.
      span_mask = (23'h01FFFF << (lo - 3'h1)) | 23'h01FFFF;
    end
    // Top region uses address bits above the span all set, bottom all clear.
    if (i_bp[3])
      in_range = ((i_addr & ~span_mask) == '0);
    else
      in_range = ((i_addr | span_mask) == '1);
    if (lo == 3'h0)
      normal = 1'b0;
    else if (lo == 3'h7)
      normal = 1'b1;
    else
      normal = in_range;
    o_protected = normal ^ i_cmp;
  end
endmodule : fsp_prot_decode

/* File: src/fsp_status_ctrl.sv */
`timescale 1ns/10ps
module fsp_status_ctrl #(
  parameter int unsigned OP_CYCLES = fsp_pkg::OP_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic i_cs_n,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [fsp_pkg::ADDR_W-1:0] i_cmd_addr,
  input wire logic [15:0] i_cmd_data,
  input wire logic i_cmd_erase_kind,
  input wire logic i_wp_n,
  output logic [15:0] o_status,
  output logic o_cmd_refused,
  output logic o_quad_pins,
  output logic [2:0] o_sec_read_only,
  output logic o_array_op_start
);
  // ----------------------------------------------------------------
  // Link side: capture a command on its valid strobe, toggle to core
  // ----------------------------------------------------------------
  logic [7:0] lk_code_reg;
  logic [fsp_pkg::ADDR_W-1:0] lk_addr_reg;
  logic [15:0] lk_data_reg;
  logic lk_kind_reg;
  logic lk_tog_reg = 1'b0;
  always_ff @(posedge i_link_clk) begin
    if (i_cmd_valid && !i_cs_n) begin
      lk_code_reg <= i_cmd_code;
      lk_addr_reg <= i_cmd_addr;
      lk_data_reg <= i_cmd_data;
      lk_kind_reg <= i_cmd_erase_kind;
      lk_tog_reg <= ~lk_tog_reg;
    end
  end

  // ----------------------------------------------------------------
  // Core side: synchronise toggle, then sample held words
  // ----------------------------------------------------------------
  logic [2:0] tog_sync_reg = 3'h0;
  logic cmd_pulse;
  logic [1:0] wp_sync_reg;
  // The toggle chain is not cleared by reset: clearing it would turn the toggle
  // left by the last command into a fresh pulse and replay that command.
  always_ff @(posedge i_core_clk) begin
    tog_sync_reg <= {tog_sync_reg[1:0], lk_tog_reg};
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst)
      wp_sync_reg <= 2'h3;
    else
      wp_sync_reg <= {wp_sync_reg[0], i_wp_n};
  end
  assign cmd_pulse = tog_sync_reg[2] ^ tog_sync_reg[1];
  logic wp_n_s;
  assign wp_n_s = wp_sync_reg[1];

  logic [7:0] code;
  logic [fsp_pkg::ADDR_W-1:0] addr;
  logic [15:0] wdata;
  logic kind;
  assign code = lk_code_reg;
  assign addr = lk_addr_reg;
  assign wdata = lk_data_reg;
  assign kind = lk_kind_reg;

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  logic busy_flag_reg;
  logic write_latch_reg;
  logic [4:0] block_protect_reg = fsp_pkg::NV_RESET[fsp_pkg::BIT_BP_LO +: 5];
  logic protect_mode_low_reg = fsp_pkg::NV_RESET[fsp_pkg::BIT_MODE_LOW];
  logic protect_mode_high_reg = fsp_pkg::NV_RESET[fsp_pkg::BIT_MODE_HIGH];
  logic quad_enable_reg = fsp_pkg::NV_RESET[fsp_pkg::BIT_QUAD];
  logic [2:0] security_lock_reg = fsp_pkg::NV_RESET[fsp_pkg::BIT_LOCK_LO +: 3];
  logic complement_reg = fsp_pkg::NV_RESET[fsp_pkg::BIT_CMP];
  logic erase_suspended_reg;
  logic program_suspended_reg;
  logic reset_armed_reg;
  logic [$clog2(OP_CYCLES+1)-1:0] op_cnt_reg;
  logic susp_kind_reg;

  // ----------------------------------------------------------------
  // Command classification and permission
  // ----------------------------------------------------------------
  logic is_status_write_cmd;
  logic is_prog;
  logic is_erase;
  logic is_chip;
  logic is_sec;
  logic addr_prot;
  logic sr_unlocked;
  logic chip_ok;
  logic accept;
  logic refuse;
  logic [4:0] bp_next;

  fsp_prot_decode u_decode (
    .i_bp(block_protect_reg),
    .i_cmp(complement_reg),
    .i_addr(addr),
    .o_protected(addr_prot)
  );

  always_comb begin
    is_status_write_cmd = (code == fsp_pkg::CMD_STATUS_WRITE_CMD);
    is_prog = (code == fsp_pkg::CMD_PP) || (code == fsp_pkg::CMD_QPP);
    is_erase = (code == fsp_pkg::CMD_SE) || (code == fsp_pkg::CMD_BE32) ||
               (code == fsp_pkg::CMD_BE64);
    is_chip = (code == fsp_pkg::CMD_CE1) || (code == fsp_pkg::CMD_CE2);
    is_sec = (code == fsp_pkg::CMD_SEC_ER) || (code == fsp_pkg::CMD_SEC_PG);
    unique case ({protect_mode_high_reg, protect_mode_low_reg})
      2'b00: sr_unlocked = 1'b1;
      2'b01: sr_unlocked = wp_n_s;
      2'b10: sr_unlocked = 1'b0;
      2'b11: sr_unlocked = 1'b0;
    endcase
    chip_ok = ((block_protect_reg[2:0] == 3'h0) && !complement_reg) ||
              ((block_protect_reg[2:0] == 3'h7) && complement_reg);
    refuse = 1'b0;
    if (is_status_write_cmd || is_prog || is_erase || is_chip || is_sec) begin
      if (!write_latch_reg || busy_flag_reg)
        refuse = 1'b1;
      else if (is_status_write_cmd && !sr_unlocked)
        refuse = 1'b1;
      else if ((is_prog || is_erase) && addr_prot)
        refuse = 1'b1;
      else if (is_chip && !chip_ok)
        refuse = 1'b1;
    end
    accept = cmd_pulse && !refuse;
    bp_next = wdata[fsp_pkg::BIT_BP_LO +: 5];
  end

  // ----------------------------------------------------------------
  // Busy flag: runs a fixed internal operation time
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      busy_flag_reg <= 1'b0;
      op_cnt_reg <= '0;
    end else if (accept && (is_status_write_cmd || is_prog || is_erase || is_chip || is_sec)) begin
      busy_flag_reg <= 1'b1;
      op_cnt_reg <= ($clog2(OP_CYCLES+1))'(OP_CYCLES - 1);
    end else if (busy_flag_reg && !(erase_suspended_reg || program_suspended_reg)) begin
      if (op_cnt_reg == '0)
        busy_flag_reg <= 1'b0;
      else
        op_cnt_reg <= op_cnt_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write latch
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst)
      write_latch_reg <= 1'b0;
    else if (cmd_pulse && code == fsp_pkg::CMD_WRITE_ENABLE_CMD)
      write_latch_reg <= 1'b1;
    else if (cmd_pulse && code == fsp_pkg::CMD_WRDI)
      write_latch_reg <= 1'b0;
    else if (accept && (is_status_write_cmd || is_prog || is_erase || is_chip || is_sec))
      write_latch_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Non-volatile fields, changed only by an accepted status write or, for lock-down mode, by reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    // A power cycle keeps the non-volatile image; only lock-down mode falls back to 00,
    // while the one-time mode 11 stays for good.
    if (i_rst) begin
      if (protect_mode_high_reg && !protect_mode_low_reg)
        protect_mode_high_reg <= 1'b0;
    end else if (accept && is_status_write_cmd) begin
      block_protect_reg <= bp_next;
      complement_reg <= wdata[fsp_pkg::BIT_CMP];
      quad_enable_reg <= wdata[fsp_pkg::BIT_QUAD];
      protect_mode_low_reg <= wdata[fsp_pkg::BIT_MODE_LOW];
      protect_mode_high_reg <= wdata[fsp_pkg::BIT_MODE_HIGH];
    end
  end

  // Lock bits are one-time; a power cycle (reset) does not clear them.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst && accept && is_status_write_cmd)
      security_lock_reg <= security_lock_reg |
                           wdata[fsp_pkg::BIT_LOCK_LO +: 3];
  end

  // ----------------------------------------------------------------
  // Suspend flags and the two-command software reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst)
      reset_armed_reg <= 1'b0;
    else if (cmd_pulse)
      reset_armed_reg <= (code == fsp_pkg::CMD_RST_EN);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst)
      susp_kind_reg <= 1'b0;
    else if (accept && (is_erase || is_chip || is_prog))
      susp_kind_reg <= is_prog ? 1'b0 : 1'b1;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      erase_suspended_reg <= 1'b0;
      program_suspended_reg <= 1'b0;
    end else if (cmd_pulse) begin
      if (code == fsp_pkg::CMD_SUSP && busy_flag_reg) begin
        if (kind || susp_kind_reg)
          erase_suspended_reg <= 1'b1;
        else
          program_suspended_reg <= 1'b1;
      end else if (code == fsp_pkg::CMD_RESUME ||
                   (code == fsp_pkg::CMD_RST && reset_armed_reg)) begin
        erase_suspended_reg <= 1'b0;
        program_suspended_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cmd_refused <= 1'b0;
      o_array_op_start <= 1'b0;
    end else begin
      o_cmd_refused <= cmd_pulse && refuse;
      o_array_op_start <= accept && (is_prog || is_erase || is_chip);
    end
  end

  always_comb begin
    o_status = {erase_suspended_reg, complement_reg, security_lock_reg,
                program_suspended_reg, quad_enable_reg, protect_mode_high_reg,
                protect_mode_low_reg, block_protect_reg, write_latch_reg,
                busy_flag_reg};
    o_quad_pins = quad_enable_reg;
    o_sec_read_only = security_lock_reg;
  end
endmodule : fsp_status_ctrl

/* File: test/fsp_host_model.sv */
`timescale 1ns/10ps
module fsp_host_model (
  output logic o_link_clk,
  output logic o_cs_n,
  output logic o_valid,
  output logic [7:0] o_code,
  output logic [fsp_pkg::ADDR_W-1:0] o_addr,
  output logic [15:0] o_data,
  output logic o_kind
);
  initial begin
    o_link_clk = 1'b0;
    o_cs_n = 1'b1;
    o_valid = 1'b0;
    o_code = 8'h00;
    o_addr = 23'h000000;
    o_data = 16'h0000;
    o_kind = 1'b0;
  end
  // The link clock runs only inside a frame, so the core sees no edges between commands.
  task automatic send(input logic [7:0] c, input logic [fsp_pkg::ADDR_W-1:0] a,
    input logic [15:0] d, input logic k);
    #($urandom_range(5, 1));
    o_cs_n = 1'b0;
    o_code = c;
    o_addr = a;
    o_data = d;
    o_kind = k;
    o_valid = 1'b1;
    #3 o_link_clk = 1'b1;
    repeat (3) begin
      #3 o_link_clk = 1'b0;
      o_valid = 1'b0;
      #3 o_link_clk = 1'b1;
    end
    #3 o_link_clk = 1'b0;
    o_cs_n = 1'b1;
  endtask : send
endmodule : fsp_host_model

/* File: test/fsp_status_ctrl_assertions.sv */
`timescale 1ns/10ps
module fsp_chk #(
  parameter int unsigned OP_CYCLES = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [15:0] o_status,
  input wire logic o_cmd_refused,
  input wire logic o_quad_pins,
  input wire logic [2:0] o_sec_read_only,
  input wire logic o_array_op_start
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_start; o_array_op_start; endsequence
  sequence s_running; o_status[0] && !o_status[1]; endsequence
  property p_start_busy; s_start |-> ##[0:1] s_running; endproperty
  property p_start_latch; s_start |-> $past(o_status[1], 2) && !$past(o_status[0], 2); endproperty
  property p_refused_pulse; o_cmd_refused |=> !o_cmd_refused; endproperty
  property p_exclusive; !(o_cmd_refused && o_array_op_start); endproperty
  property p_quad; o_quad_pins == o_status[9]; endproperty
  property p_sec_ro; o_sec_read_only == o_status[13:11]; endproperty
  // Counts how long busy has stood, so an operation that ends early shows up.
  int unsigned busy_cnt_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !o_status[0])
      busy_cnt_reg <= 0;
    else if (busy_cnt_reg < OP_CYCLES)
      busy_cnt_reg <= busy_cnt_reg + 1;
  end
  property p_busy_time;
    !$past(i_rst) && $fell(o_status[0]) |-> busy_cnt_reg >= OP_CYCLES;
  endproperty
  // Lock bits survive reset, so this one stays armed through it.
  property p_lock_keep(b); disable iff (1'b0) b |=> b; endproperty
  property p_sr_frozen; $past(o_status[8]) |-> $stable({o_status[14:11], o_status[9:2]}); endproperty
  property p_reset;
    disable iff (1'b0) i_rst |=> (o_status & 16'h8403) == 16'h0000 &&
      !(o_status[8] && !o_status[7]) && !o_array_op_start;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start without busy");
  a_busy_time: assert property (p_busy_time)
    else $error("busy ended before the operation time");
  a_start_latch: assert property (p_start_latch)
    else $error("start without latch");
  a_refused_pulse: assert property (p_refused_pulse)
    else $error("refusal longer than one cycle");
  a_exclusive: assert property (p_exclusive)
    else $error("start and refusal together");
  a_quad: assert property (p_quad)
    else $error("quad pins differ from status");
  a_sec_ro: assert property (p_sec_ro)
    else $error("read-only flags differ from locks");
  a_sr_frozen: assert property (p_sr_frozen)
    else $error("status changed in locked mode");
  a_reset: assert property (p_reset)
    else $error("status not cleared by reset");
  for (genvar k = 11; k < 14; k++) begin : g_lock
    a_lock_keep: assert property (p_lock_keep(o_status[k]))
      else $error("lock bit cleared");
  end
endmodule : fsp_chk
bind fsp_status_ctrl fsp_chk #(.OP_CYCLES(OP_CYCLES)) fsp_chk_inst (.i_core_clk(i_core_clk),
  .i_rst(i_rst), .o_status(o_status), .o_cmd_refused(o_cmd_refused),
  .o_quad_pins(o_quad_pins), .o_sec_read_only(o_sec_read_only),
  .o_array_op_start(o_array_op_start));

/* File: test/tb_fsp_status_ctrl.sv */
`timescale 1ns/10ps
module tb_fsp_status_ctrl;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic link_clk, cs_n, valid, kind, quad, refused, start, cm, s;
  logic [7:0] code, op;
  logic [fsp_pkg::ADDR_W-1:0] addr, a;
  logic [15:0] data, status, m;
  logic [2:0] sec_ro;
  logic [4:0] bp;
  int n_errors = 0;
  int comparisons = 0;
  int n_start, n_ref;
  logic [7:0] ops [7] = '{fsp_pkg::CMD_PP, fsp_pkg::CMD_QPP, fsp_pkg::CMD_SE,
    fsp_pkg::CMD_BE32, fsp_pkg::CMD_BE64, fsp_pkg::CMD_CE1, fsp_pkg::CMD_CE2};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    n_start += int'(start === 1'b1);
    n_ref += int'(refused === 1'b1);
  end
  fsp_host_model fsp_host_model_inst (.o_link_clk(link_clk), .o_cs_n(cs_n), .o_valid(valid),
    .o_code(code), .o_addr(addr), .o_data(data), .o_kind(kind));
  fsp_status_ctrl #(.OP_CYCLES(100)) fsp_status_ctrl_inst (.i_core_clk(core_clk), .i_rst(rst),
    .i_link_clk(link_clk), .i_cs_n(cs_n), .i_cmd_valid(valid), .i_cmd_code(code),
    .i_cmd_addr(addr), .i_cmd_data(data), .i_cmd_erase_kind(kind), .i_wp_n(wp_n),
    .o_status(status), .o_cmd_refused(refused), .o_quad_pins(quad),
    .o_sec_read_only(sec_ro), .o_array_op_start(start));
  function automatic logic prot(input logic [4:0] b, input logic c, input logic [22:0] ad);
    int sz;
    logic hit;
    sz = b[4] ? ((b[2:0] >= 3'h4) ? 15 : 11 + b[2:0]) : 16 + b[2:0];
    hit = b[3] ? (ad < (1 << sz)) : (ad >= (24'h800000 - (1 << sz)));
    if (b[2:0] == 3'h0) hit = 1'b0;
    if (b[2:0] == 3'h7) hit = 1'b1;
    return hit ^ c;
  endfunction : prot
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mk);
    comparisons++;
    if ((got & mk) !== (exp & mk)) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & mk, exp & mk);
    end
  endtask : chk
  task automatic ev(input logic st);
    chk({8'(n_start), 8'(n_ref)}, {7'h00, st, 7'h00, !st}, 16'hFFFF);
  endtask : ev
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic cmd(input logic [7:0] c, input logic [22:0] ad = 23'h000000,
    input logic [15:0] d = 16'h0000, input logic k = 1'b0);
    n_start = 0;
    n_ref = 0;
    fsp_host_model_inst.send(c, ad, d, k);
    tick(10);
  endtask : cmd
  task automatic idle;
    int i;
    for (i = 0; i < 300 && status[0] !== 1'b0; i++) tick(1);
    if (i == 300) begin
      n_errors++;
      stop_test();
    end
  endtask : idle
  task automatic status_write_cmd(input logic [15:0] d);
    cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
    cmd(fsp_pkg::CMD_STATUS_WRITE_CMD, 23'h000000, d);
    chk(status, 16'h0001, 16'h0003);
    idle();
  endtask : status_write_cmd
  task automatic pwr;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
  endtask : pwr
  initial begin
    void'($urandom(32'h7E94));
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    tick(2);
    chk(status, 16'h0000, 16'hC7FF);
    cmd(fsp_pkg::CMD_PP);
    ev(1'b0);
    cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
    chk(status, 16'h0002, 16'h0003);
    cmd(fsp_pkg::CMD_WRDI);
    chk(status, 16'h0000, 16'h0003);
    cm = 1'($urandom);
    status_write_cmd(16'hC803 | {6'h00, cm, 9'h000});
    chk(status, 16'h4800 | {6'h00, cm, 9'h000}, 16'hCFFF);
    chk({15'h0000, quad}, {15'h0000, cm}, 16'h0001);
    chk({13'h0000, sec_ro}, 16'h0001, 16'h0007);
    status_write_cmd(16'h0000);
    chk(status, 16'h0800, 16'hCFFF);
    pwr();
    chk(status, 16'h0800, 16'hCFFF);
    for (int i = 0; i < 21; i++) begin
      bp = 5'($urandom);
      cm = 1'($urandom);
      a = 23'($urandom);
      if (i % 3 == 0) a[22:12] = 11'h7FF;
      if (i % 3 == 1) a[22:15] = 8'h00;
      op = ops[i % 7];
      status_write_cmd({1'b0, cm, 7'h00, bp, 2'b00});
      chk(status, {1'b0, cm, 7'h00, bp, 2'b00}, 16'h407C);
      cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
      cmd(op, a);
      s = (op == fsp_pkg::CMD_CE1 || op == fsp_pkg::CMD_CE2) ?
        ((bp[2:0] == 3'h0 && !cm) || (bp[2:0] == 3'h7 && cm)) : !prot(bp, cm, a);
      ev(s);
      idle();
    end
    status_write_cmd(16'h0080);
    wp_n = 1'b0;
    tick(4);
    cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
    cmd(fsp_pkg::CMD_STATUS_WRITE_CMD, 23'h000000, 16'h0084);
    ev(1'b0);
    chk(status, 16'h0080, 16'h01FC);
    wp_n = 1'b1;
    tick(4);
    for (int j = 0; j < 2; j++) begin
      m = j ? 16'h0180 : 16'h0104;
      status_write_cmd(m);
      chk(status, m, 16'h01FC);
      cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
      cmd(fsp_pkg::CMD_STATUS_WRITE_CMD, 23'h000000, 16'h0000);
      ev(1'b0);
      chk(status, m, 16'h01FC);
      pwr();
      chk(status, j ? 16'h0180 : 16'h0004, 16'h01FC);
    end
    cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
    cmd(fsp_pkg::CMD_PP, 23'h001000);
    ev(1'b1);
    cmd(fsp_pkg::CMD_SUSP);
    chk(status, 16'h0400, 16'h8400);
    cmd(fsp_pkg::CMD_RESUME);
    chk(status, 16'h0000, 16'h8400);
    cmd(fsp_pkg::CMD_SUSP, 23'h000000, 16'h0000, 1'b1);
    chk(status, 16'h8000, 16'h8400);
    cmd(fsp_pkg::CMD_RST_EN);
    cmd(fsp_pkg::CMD_RST);
    chk(status, 16'h0000, 16'h8400);
    stop_test();
  end
endmodule : tb_fsp_status_ctrl
